// >>> rtl/adcsq_pkg.sv
// Purpose: shared constants for the converter sequencer register block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   offsets are byte addresses
`default_nettype none
package adcsq_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h00;  // converter_control
  localparam logic [7:0] OFS_RES_HIGH   = 8'h04;  // result_high_byte
  localparam logic [7:0] OFS_RES_LOW    = 8'h08;  // result_low_nibble
  localparam logic [7:0] OFS_CLK_CFG    = 8'h0C;  // converter_clock_config
  localparam logic [7:0] OFS_PIN_CFG    = 8'h10;  // analog pin enables
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;  // sticky events, read only
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;  // write one to clear
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;  // event mask
  // field positions
  localparam int CTL_START_BIT  = 7;  // start control bit
  localparam int CTL_BUSY_BIT   = 6;  // conversion_busy_flag
  localparam int CLK_OFF_BIT    = 6;  // converter power off (eight-input build)
  localparam int CLK_DIV_W      = 3;  // clock_divider_select width
  localparam int RES_W          = 12; // result width
  localparam int IRQ_DONE_BIT   = 0;  // end-of-conversion event
  // reset values
  localparam logic       RST_BUSY    = 1'b1;
  localparam logic       RST_START   = 1'b0;
  localparam logic       RST_CONV_OFF = 1'b1;
  localparam logic [2:0] RST_DIV     = 3'h0;
  // divider codes
  localparam logic [2:0] DIV_CODE_2   = 3'h0;
  localparam logic [2:0] DIV_CODE_8   = 3'h1;
  localparam logic [2:0] DIV_CODE_32  = 3'h2;
  localparam logic [2:0] DIV_CODE_1   = 3'h4;
  localparam logic [2:0] DIV_CODE_4   = 3'h5;
  localparam logic [2:0] DIV_CODE_16  = 3'h6;
  // converter clock periods per conversion
  localparam int CONV_TICKS = 16;
  localparam int DIV_CNT_W  = 5;
  // engine states
  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN} adcsq_eng_state_type;
endpackage
`default_nettype wire

// >>> rtl/adcsq_eng_if.sv
// Purpose: link between the register block and the conversion engine
// Assumes: single pclk domain
// Notes:   ctrl drives requests, eng answers
`default_nettype none
interface adcsq_eng_if;
  logic       hold_reset;  // converter held in reset
  logic       launch;      // one-cycle conversion start
  logic [2:0] div_code;    // clock_divider_select
  logic       tick;        // converter clock enable pulse
  logic       done;        // one-cycle end of conversion
  logic       running;     // conversion under way
  modport ctrl (output hold_reset, output launch, output div_code,
                input tick, input done, input running);
  modport eng  (input hold_reset, input launch, input div_code,
                output tick, output done, output running);
endinterface
`default_nettype wire

// >>> rtl/adcsq_conv_engine.sv
// Purpose: converter clock divider and conversion period counter
// Assumes: launch is a single-cycle pulse
// Notes:   undefined divider codes fall back to the slowest ratio
`default_nettype none
module adcsq_conv_engine (
  input  wire logic  pclk,
  input  wire logic  presetn,
  adcsq_eng_if.eng   eng
);
  // terminal count of the divider for each select code
  function automatic logic [4:0] div_last(input logic [2:0] code);
    case (code)
      adcsq_pkg::DIV_CODE_1:  div_last = 5'h00;
      adcsq_pkg::DIV_CODE_2:  div_last = 5'h01;
      adcsq_pkg::DIV_CODE_4:  div_last = 5'h03;
      adcsq_pkg::DIV_CODE_8:  div_last = 5'h07;
      adcsq_pkg::DIV_CODE_16: div_last = 5'h0F;
      adcsq_pkg::DIV_CODE_32: div_last = 5'h1F;
      default:                div_last = 5'h1F;  // undefined code, keep it slow
    endcase
  endfunction

  logic [4:0]                    div_q;    // divider count
  logic [4:0]                    cnt_q;    // converter periods elapsed
  adcsq_pkg::adcsq_eng_state_type state_q; // engine state

  // free-running divider; restarts when the count passes a new, lower limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 5'h00;
    end else if (div_q >= div_last(eng.div_code)) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end
  assign eng.tick = (div_q >= div_last(eng.div_code));

  // conversion runs a fixed number of converter clock periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adcsq_pkg::ENG_IDLE;
      cnt_q   <= 5'h00;
    end else begin
      case (state_q)
        adcsq_pkg::ENG_IDLE: begin
          cnt_q <= 5'h00;
          if (eng.launch && !eng.hold_reset) begin
            state_q <= adcsq_pkg::ENG_RUN;
          end
        end
        adcsq_pkg::ENG_RUN: begin
          if (eng.hold_reset) begin
            state_q <= adcsq_pkg::ENG_IDLE;  // aborted by a raised start bit
          end else if (eng.tick) begin
            if (cnt_q == 5'(adcsq_pkg::CONV_TICKS - 1)) begin
              state_q <= adcsq_pkg::ENG_IDLE;
            end
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: state_q <= adcsq_pkg::ENG_IDLE;
      endcase
    end
  end
  assign eng.running = (state_q == adcsq_pkg::ENG_RUN);
  assign eng.done    = eng.running && !eng.hold_reset && eng.tick
                       && (cnt_q == 5'(adcsq_pkg::CONV_TICKS - 1));

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    eng.tick && div_last(eng.div_code) != 5'h00 && $stable(eng.div_code)
    |=> !eng.tick) else $error("converter tick came too soon");
  a_done_count: assert property (@(posedge pclk) disable iff (!presetn)
    eng.done |-> cnt_q == 5'(adcsq_pkg::CONV_TICKS - 1) && eng.running)
    else $error("conversion ended at the wrong count");
endmodule
`default_nettype wire

// >>> rtl/adcsq_regs.sv
// Purpose: APB register block and start sequencing for a 12-bit converter
// Assumes: converter core result is synchronous to pclk
// Notes:   one wait state on every APB access
//
// Contract
// - result is unsigned and twelve bits
// - high byte holds result bits 11..4
// - low register upper nibble holds bits 3..0
// - unimplemented bits read zero, ignore writes
// - result registers updated when conversion completes
// - start low-high-low launches one conversion
// - start held high resets converter, busy set
// - busy shows progress; resets busy 1, start 0
// - one converter shared, channel select routes input
// - two, four or eight inputs, select width
// - eight inputs: binary channel index
// - pin enable one makes pin analog
// - eight inputs: enable zero returns digital pin
// - small builds: all zero powers converter down
// - busy clears itself at conversion end
// - conversion end sets flag, raises interrupt
// - converter clock divided by selected ratio
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`default_nettype none
module adcsq_regs #(
  parameter int NUM_CH = 8  // analog inputs: 2, 4 or 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [11:0]          conv_result,
  output logic      [2:0]           mux_sel,
  output logic      [7:0]           analog_pin_en,
  output logic                      conv_reset,
  output logic                      conv_power_down,
  output logic                      conv_clk_en,
  output logic                      irq
);
  // select width follows the input count
  localparam int SEL_W = (NUM_CH == 8) ? 3 : ((NUM_CH == 4) ? 2 : 1);

  // maps an APB byte offset onto a valid flag
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      adcsq_pkg::OFS_CONTROL, adcsq_pkg::OFS_RES_HIGH, adcsq_pkg::OFS_RES_LOW,
      adcsq_pkg::OFS_CLK_CFG, adcsq_pkg::OFS_PIN_CFG, adcsq_pkg::OFS_IRQ_STATUS,
      adcsq_pkg::OFS_IRQ_CLEAR, adcsq_pkg::OFS_IRQ_ENABLE: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  adcsq_eng_if eng_if ();  // link to the conversion engine

  // register state
  logic                start_q;       // start control bit
  logic                busy_q;        // conversion_busy_flag
  logic [SEL_W-1:0]    chan_sel_q;    // channel_select
  logic [2:0]          div_sel_q;     // clock_divider_select
  logic                conv_off_q;    // power off, eight-input build only
  logic [NUM_CH-1:0]   pin_en_q;      // analog pin enables
  logic [11:0]         result_q;      // last converted value
  logic                launch_q;      // one-cycle conversion launch
  logic                done_d1_q;     // result stored, busy falls next
  logic                irq_status_q;  // sticky end-of-conversion event
  logic                irq_enable_q;  // event mask
  logic                pready_q;      // access wait state done
  logic [31:0]         prdata_q;      // read data
  logic [31:0]         rd_d;          // read data mux
  logic                acc_phase;     // access phase of a transfer
  logic                wr_en;         // write takes effect this edge
  logic                start_wr;      // control write this edge
  logic                start_new;     // start value being written

  // a write completes only on the edge where pready is seen high
  assign acc_phase = psel && penable;
  assign wr_en     = acc_phase && pready_q && pwrite && addr_known(paddr);
  assign start_wr  = wr_en && (paddr == adcsq_pkg::OFS_CONTROL);
  assign start_new = pwdata[adcsq_pkg::CTL_START_BIT];

  // one wait state gives time to register the read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc_phase && !pready_q;
    end
  end
  assign pready  = pready_q;
  assign pslverr = pready_q && acc_phase && !addr_known(paddr);  // unmapped answers error

  // read mux; every unlisted bit is a constant zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      adcsq_pkg::OFS_CONTROL: begin
        rd_d[adcsq_pkg::CTL_START_BIT] = start_q;
        rd_d[adcsq_pkg::CTL_BUSY_BIT]  = busy_q;
        rd_d[SEL_W-1:0]                = chan_sel_q;
      end
      adcsq_pkg::OFS_RES_HIGH: rd_d[7:0] = result_q[11:4];
      adcsq_pkg::OFS_RES_LOW:  rd_d[7:4] = result_q[3:0];
      adcsq_pkg::OFS_CLK_CFG: begin
        rd_d[adcsq_pkg::CLK_DIV_W-1:0] = div_sel_q;
        rd_d[adcsq_pkg::CLK_OFF_BIT]   = (NUM_CH == 8) ? conv_off_q : 1'b0;
      end
      adcsq_pkg::OFS_PIN_CFG:    rd_d[NUM_CH-1:0] = pin_en_q;
      adcsq_pkg::OFS_IRQ_STATUS: rd_d[adcsq_pkg::IRQ_DONE_BIT] = irq_status_q;
      adcsq_pkg::OFS_IRQ_ENABLE: rd_d[adcsq_pkg::IRQ_DONE_BIT] = irq_enable_q;
      default: rd_d = 32'h0000_0000;  // clear register and unmapped read zero
    endcase
  end

  // read data captured during the wait state, held until the next read access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (acc_phase && !pready_q && !pwrite) begin
      prdata_q <= rd_d;
    end
  end
  assign prdata = prdata_q;

  // channel select: only the implemented bits are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_sel_q <= '0;
    end else if (start_wr) begin
      chan_sel_q <= pwdata[SEL_W-1:0];
    end
  end

  // clock configuration and pin enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sel_q  <= adcsq_pkg::RST_DIV;
      conv_off_q <= adcsq_pkg::RST_CONV_OFF;
      pin_en_q   <= '0;
    end else if (wr_en) begin
      if (paddr == adcsq_pkg::OFS_CLK_CFG) begin
        div_sel_q  <= pwdata[adcsq_pkg::CLK_DIV_W-1:0];
        conv_off_q <= pwdata[adcsq_pkg::CLK_OFF_BIT];
      end
      if (paddr == adcsq_pkg::OFS_PIN_CFG) begin
        pin_en_q <= pwdata[NUM_CH-1:0];
      end
    end
  end

  // start bit; the falling write of a raised start bit launches once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q  <= adcsq_pkg::RST_START;
      launch_q <= 1'b0;
    end else begin
      launch_q <= start_wr && start_q && !start_new;
      if (start_wr) begin
        start_q <= start_new;
      end
    end
  end

  // busy flag: set while start is up or a conversion runs, cleared after result;
  // a raising start write sets busy on the same edge as start, so that software
  // never sees start high with busy low after an earlier conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= adcsq_pkg::RST_BUSY;
    end else if (start_q || launch_q || (start_wr && start_new)) begin
      busy_q <= 1'b1;
    end else if (done_d1_q) begin
      busy_q <= 1'b0;
    end
  end

  // result stored first, busy and the event follow a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q  <= 12'h000;
      done_d1_q <= 1'b0;
    end else begin
      done_d1_q <= eng_if.done;
      if (eng_if.done) begin
        result_q <= conv_result;
      end
    end
  end

  // sticky event; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 1'b0;
      irq_enable_q <= 1'b0;
    end else begin
      if (done_d1_q) begin
        irq_status_q <= 1'b1;
      end else if (wr_en && paddr == adcsq_pkg::OFS_IRQ_CLEAR
                   && pwdata[adcsq_pkg::IRQ_DONE_BIT]) begin
        irq_status_q <= 1'b0;
      end
      if (wr_en && paddr == adcsq_pkg::OFS_IRQ_ENABLE) begin
        irq_enable_q <= pwdata[adcsq_pkg::IRQ_DONE_BIT];
      end
    end
  end
  assign irq = irq_status_q && irq_enable_q;

  // engine hookup
  assign eng_if.hold_reset = start_q;
  assign eng_if.launch     = launch_q;
  assign eng_if.div_code   = div_sel_q;

  adcsq_conv_engine u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .eng     (eng_if.eng)
  );

  // analog side: the binary index drives the shared converter's multiplexer
  assign mux_sel         = 3'(chan_sel_q);
  assign analog_pin_en   = 8'(pin_en_q);
  assign conv_reset      = start_q;
  assign conv_clk_en     = eng_if.tick && eng_if.running;
  // small builds power down when no pin is analog; the wide build has its own bit
  assign conv_power_down = (NUM_CH == 8) ? conv_off_q : (pin_en_q == '0);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_busy: assert property (start_q |-> busy_q && conv_reset)
    else $error("raised start did not hold busy and reset");
  a_launch_fall: assert property ($fell(start_q) |-> launch_q)
    else $error("start pulse did not launch");
  a_launch_run: assert property (launch_q && !start_q |=> eng_if.running)
    else $error("launch did not start the engine");
  a_high_read: assert property (acc_phase && !pready_q && !pwrite
    && paddr == adcsq_pkg::OFS_RES_HIGH
    |=> prdata == {24'h000000, $past(result_q[11:4])})
    else $error("high byte read wrong");
  a_low_read: assert property (acc_phase && !pready_q && !pwrite
    && paddr == adcsq_pkg::OFS_RES_LOW
    |=> prdata == {24'h000000, $past(result_q[3:0]), 4'h0})
    else $error("low nibble read wrong");
  a_result_store: assert property (eng_if.done |=> result_q == $past(conv_result)
    && busy_q) else $error("result not stored before busy fell");
  a_busy_clear: assert property (done_d1_q && !start_q && !launch_q
    && !(start_wr && start_new) |=> !busy_q)
    else $error("busy did not clear at conversion end");
  a_irq_raise: assert property (done_d1_q |=> irq_status_q ##0 (irq == irq_enable_q))
    else $error("end event not flagged");
  a_power_down: assert property (NUM_CH < 8 && pin_en_q == '0 |-> conv_power_down)
    else $error("converter not powered down");
  a_mux_route: assert property (start_wr |=> mux_sel == 3'($past(pwdata[SEL_W-1:0])))
    else $error("channel select not routed");
endmodule
`default_nettype wire

// >>> tb/adcsq_conv_model.sv
// Purpose: behavioural analog input mux and sampling converter core
// Assumes: the block samples the result only when a conversion ends
// Notes:   held or powered-down core gives a wandering value, never a stale one
`default_nettype none
module adcsq_conv_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [2:0]  mux_sel,
  input  wire logic        conv_reset,
  input  wire logic        conv_power_down,
  output logic      [11:0] conv_result
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] junk_q;  // changes every cycle while no valid sample exists

  // free-running pattern for the idle output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_q <= 12'hFFF;
    end else begin
      junk_q <= junk_q + 12'h5A3;
    end
  end

  // each input settles to its own level, so a wrong route shows in the result
  always_comb begin
    if (conv_reset || conv_power_down) begin
      conv_result = junk_q;
    end else begin
      conv_result = {4'hA ^ {1'b0, mux_sel}, 4'h5, 1'b0, mux_sel};
    end
  end
endmodule
`default_nettype wire

// >>> tb/adcsq_regs_test.sv
// Purpose: self-checking bench for the converter sequencer register block
// Assumes: eight-input build, APB with one wait state
// Notes:   result levels come from the converter model, one per channel
`default_nettype none
module adcsq_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite;  // clock, reset, APB controls
  logic [7:0]  paddr, analog_pin_en;                  // address, pin enables
  logic [31:0] pwdata, prdata, rd;                    // bus data, last read
  logic        pready, pslverr, err;                  // answer, error, last error
  logic [11:0] conv_result;                           // converter core result
  logic [2:0]  mux_sel;                               // routed channel
  logic        conv_reset, conv_power_down, conv_clk_en, irq;
  int          n_fail, samples_checked;               // verdict counters

  adcsq_regs #(.NUM_CH(8)) adcsq_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_result(conv_result), .mux_sel(mux_sel), .analog_pin_en(analog_pin_en),
    .conv_reset(conv_reset), .conv_power_down(conv_power_down),
    .conv_clk_en(conv_clk_en), .irq(irq));
  adcsq_conv_model adcsq_conv_model_inst (
    .pclk(pclk), .presetn(presetn), .mux_sel(mux_sel), .conv_reset(conv_reset),
    .conv_power_down(conv_power_down), .conv_result(conv_result));

  // free-running 10 MHz clock
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one comparison, reported at once when it differs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write edge's updates settle before callers look at outputs
    @(negedge pclk);
  endtask

  // read one register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  // full start pulse, conversion, readback and event clear
  task automatic convert(input logic [2:0] ch, input logic [2:0] code);
    int          div, cyc, pulses;
    logic [11:0] e;
    div = (code == 3'h0) ? 2 : (code == 3'h1) ? 8 : 32;
    cyc = 0;
    pulses = 0;
    e = {4'hA ^ {1'b0, ch}, 4'h5, 1'b0, ch};
    apb(adcsq_pkg::OFS_CLK_CFG, 1'b1, {29'h0, code});
    check({31'h0, conv_power_down}, 32'h0);
    apb(adcsq_pkg::OFS_CONTROL, 1'b1, 32'h80 | {29'h0, ch});
    // start held high: converter must stay in reset and not run
    repeat (20) begin
      @(posedge pclk);
      pulses += int'(conv_clk_en === 1'b1);
    end
    check(32'(pulses), 32'h0);
    check({31'h0, conv_reset}, 32'h1);
    rd_chk(adcsq_pkg::OFS_CONTROL, 32'hC0 | {29'h0, ch});
    apb(adcsq_pkg::OFS_CONTROL, 1'b1, {29'h0, ch});
    pulses = 0;
    while (irq !== 1'b1 && cyc < 1000) begin
      @(posedge pclk);
      cyc++;
      pulses += int'(conv_clk_en === 1'b1);
    end
    check(32'(pulses), 32'(adcsq_pkg::CONV_TICKS));
    check({31'h0, cyc >= 15 * div + 1 && cyc <= 16 * div + 8}, 32'h1);
    check({29'h0, mux_sel}, {29'h0, ch});
    rd_chk(adcsq_pkg::OFS_CONTROL, {29'h0, ch});
    rd_chk(adcsq_pkg::OFS_RES_HIGH, {24'h0, e[11:4]});
    rd_chk(adcsq_pkg::OFS_RES_LOW, {24'h0, e[3:0], 4'h0});
    rd_chk(adcsq_pkg::OFS_IRQ_STATUS, 32'h1);
    // masking hides the line but keeps the sticky event
    if (ch == 3'h3) begin
      apb(adcsq_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h0);
      check({31'h0, irq}, 32'h0);
      apb(adcsq_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h1);
      check({31'h0, irq}, 32'h1);
    end
    apb(adcsq_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h1);
    rd_chk(adcsq_pkg::OFS_IRQ_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  // watchdog: all conversions fit well inside this span
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    test_done();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(adcsq_pkg::OFS_CONTROL, 32'h40);
    rd_chk(adcsq_pkg::OFS_CLK_CFG, 32'h40);
    rd_chk(adcsq_pkg::OFS_PIN_CFG, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    // busy bit and unused bits ignore writes; select lands in low bits
    apb(adcsq_pkg::OFS_CONTROL, 1'b1, 32'hFFFFFF3F);
    rd_chk(adcsq_pkg::OFS_CONTROL, 32'h47);
    check({29'h0, mux_sel}, 32'h7);
    apb(adcsq_pkg::OFS_PIN_CFG, 1'b1, 32'hFFFFFFFF);
    check({24'h0, analog_pin_en}, 32'hFF);
    rd_chk(adcsq_pkg::OFS_PIN_CFG, 32'hFF);
    apb(adcsq_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h1);
    // every channel, divider codes 0, 1 and 2 in turn (ratios 2, 8, 32)
    for (int i = 0; i < 8; i++) begin
      convert(3'(i), 3'(i % 3));
    end
    // result registers are read-only: last result survives writes
    apb(adcsq_pkg::OFS_RES_HIGH, 1'b1, 32'h0);
    apb(adcsq_pkg::OFS_RES_LOW, 1'b1, 32'hFF);
    rd_chk(adcsq_pkg::OFS_RES_HIGH, 32'hD5);
    rd_chk(adcsq_pkg::OFS_RES_LOW, 32'h70);
    apb(adcsq_pkg::OFS_PIN_CFG, 1'b1, 32'h0);
    check({24'h0, analog_pin_en}, 32'h0);
    apb(adcsq_pkg::OFS_CLK_CFG, 1'b1, 32'hFFFFFFFF);
    check({31'h0, conv_power_down}, 32'h1);
    rd_chk(adcsq_pkg::OFS_CLK_CFG, 32'h47);
    test_done();
  end
endmodule
`default_nettype wire
